/* File: mmoi_host.sv */
// APB host model that drives the register bus
`timescale 1ns/10ps
module mmoi_host (
	input wire pclk,
	output reg psel,
	output reg penable,
	output reg pwrite,
	output reg [11:0] paddr,
	output reg [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
	end
	task xfer(input [11:0] a, input [31:0] d, input w, output [31:0] r, output e);
		begin
			// Every change follows a rising edge directly
			@(posedge pclk);
			psel <= 1'b1;
			penable <= 1'b0;
			paddr <= a;
			pwrite <= w;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (pready !== 1'b1)
				@(posedge pclk);
			r = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			// Released data is inverted so a stale value never passes
			pwdata <= ~d;
			@(posedge pclk);
		end
	endtask
endmodule

/* File: mmoi_regs.vh */
// Register map, field positions and reset values for the motion mode block
`ifndef MMOI_REGS_VH
`define MMOI_REGS_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define MMOI_AXIS_SELECT_ADDR 12'h000
`define MMOI_MOTION_MODE_ADDR 12'h004
`define MMOI_OUTPUT_LEVELS_ADDR 12'h008
`define MMOI_INTERP_MODE_ADDR 12'h00c
`define MMOI_JOG_STATUS_ADDR 12'h010
`define MMOI_INTERP_STEP_ADDR 12'h014

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MMOI_MODE_RESET 16'h0000
`define MMOI_OUT_RESET 16'h0000
`define MMOI_INTERP_RESET 16'h0000

// ----------------------------------------------------------------
// Motion mode fields
// ----------------------------------------------------------------
`define MMOI_MANUAL_DECEL_BIT 0
`define MMOI_ASYM_BIT 1
`define MMOI_SCURVE_BIT 2
`define MMOI_JOG_LO_BIT 3
`define MMOI_JOG_HI_BIT 4
`define MMOI_STATUS_OUT_BIT 7
`define MMOI_UPPER_LSB 8
`define MMOI_MODE_WRITABLE 16'h0f9f

// ----------------------------------------------------------------
// Jog mode codes
// ----------------------------------------------------------------
`define MMOI_JOG_CONT 2'h1
`define MMOI_JOG_FIXED 2'h2

// ----------------------------------------------------------------
// Interpolation mode fields
// ----------------------------------------------------------------
`define MMOI_MASTER_LSB 0
`define MMOI_SECOND_LSB 2
`define MMOI_THIRD_LSB 4
`define MMOI_VSPEED_LSB 8
`define MMOI_EXT_STEP_BIT 11
`define MMOI_CMD_STEP_BIT 12
`define MMOI_INTERP_IRQ_BIT 14
`define MMOI_PATTERN_IRQ_BIT 15
`define MMOI_VSPEED_OFF 2'h0
`define MMOI_VSPEED_TWO 2'h1
`define MMOI_VSPEED_THREE 2'h3
`define MMOI_VSPEED_BAD 2'h2
`define MMOI_INTERP_WRITABLE 16'hdb3f

`endif

/* File: mmoi_top.v */
// Per-axis motion mode, general output and interpolation mode registers over APB
//
// Operation
// - Mode writes reach only the selected axis
// - Decel select picks automatic or manual point
// - Asymmetry bit picks separate decel rates
// - Profile bit picks trapezoid or S-curve
// - Jog field: off, continuous, fixed, off
// - Continuous jog drives while input low
// - Fixed jog starts on input falling edge
// - Pulser mode starts on plus input edges
// - Status bit clear drives upper outputs directly
// - Compare pins follow counter against compare values
// - Status pins show accelerating and decelerating
// - Upper level bits give low or high
// - Mode register clears; reserved bits stay zero
// - Output register drives lower outputs, clears low
// - Two-bit axis codes for three interpolation axes
// - Third axis code ignored in two-axis interpolation
// - Vector speed field decodes; code 10 refused
// - External step bit steps on external input
// - Command step bit steps on host command
// - Interrupt enables gate interpolation interrupts
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`include "mmoi_regs.vh"

module mmoi_top #(
	parameter AXES = 4
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [AXES-1:0] jog_plus_in_n,
	input wire [AXES-1:0] jog_minus_in_n,
	input wire external_step_input_n,
	input wire [AXES-1:0] pos_at_or_above_plus,
	input wire [AXES-1:0] pos_below_minus,
	input wire [AXES-1:0] drive_accelerating,
	input wire [AXES-1:0] drive_decelerating,
	input wire interp_two_axis,
	input wire interp_event,
	input wire pattern_interp_event,
	output reg [AXES*4-1:0] upper_axis_outputs,
	output reg [AXES*4-1:0] lower_axis_outputs,
	output reg [AXES-1:0] manual_decel_select,
	output reg [AXES-1:0] ramp_asymmetry_select,
	output reg [AXES-1:0] s_curve_select,
	output reg [AXES-1:0] jog_plus_continuous,
	output reg [AXES-1:0] jog_minus_continuous,
	output reg [AXES-1:0] jog_plus_start,
	output reg [AXES-1:0] jog_minus_start,
	output reg [1:0] master_axis_code,
	output reg [1:0] second_axis_code,
	output reg [1:0] third_axis_code,
	output reg [1:0] vector_speed_mode,
	output reg interp_step,
	output reg interp_irq
);

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	reg [1:0] axis_sel;
	reg [15:0] axis_motion_mode [0:AXES-1];
	reg [15:0] general_output_levels;
	reg [15:0] interpolation_mode;
	reg [AXES-1:0] plus_s1, plus_s2, plus_s3;
	reg [AXES-1:0] minus_s1, minus_s2;
	reg ext_s1, ext_s2, ext_s3;
	reg cmd_step_req;
	integer i;
	integer j;

	// ----------------------------------------------------------------
	// Field helpers
	// ----------------------------------------------------------------
	function [1:0] field2;
		input [15:0] word;
		input integer lsb;
		begin
			field2 = word[lsb +: 2];
		end
	endfunction

	wire wr_access = psel & penable & pwrite;
	wire addr_ok = (paddr == `MMOI_AXIS_SELECT_ADDR) || (paddr == `MMOI_MOTION_MODE_ADDR) ||
		(paddr == `MMOI_OUTPUT_LEVELS_ADDR) || (paddr == `MMOI_INTERP_MODE_ADDR) ||
		(paddr == `MMOI_JOG_STATUS_ADDR) || (paddr == `MMOI_INTERP_STEP_ADDR);
	wire [1:0] vspeed_wr = field2(pwdata[15:0], `MMOI_VSPEED_LSB);

	// Single-cycle access phase keeps the bus simple; no wait states needed
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;

	function [1:0] jog_code;
		input [15:0] mode;
		begin
			jog_code = {mode[`MMOI_JOG_HI_BIT], mode[`MMOI_JOG_LO_BIT]};
		end
	endfunction

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			axis_sel <= 2'h0;
			general_output_levels <= `MMOI_OUT_RESET;
			interpolation_mode <= `MMOI_INTERP_RESET;
			cmd_step_req <= 1'b0;
			for (i = 0; i < AXES; i = i + 1) begin
				axis_motion_mode[i] <= `MMOI_MODE_RESET;
			end
		end else begin
			cmd_step_req <= 1'b0;
			if (wr_access) begin
				case (paddr)
					`MMOI_AXIS_SELECT_ADDR: begin
						axis_sel <= pwdata[1:0];
					end
					`MMOI_MOTION_MODE_ADDR: begin
						// Reserved bits forced to zero so a careless host cannot wake them
						axis_motion_mode[axis_sel] <= pwdata[15:0] & `MMOI_MODE_WRITABLE;
					end
					`MMOI_OUTPUT_LEVELS_ADDR: begin
						general_output_levels <= pwdata[15:0];
					end
					`MMOI_INTERP_MODE_ADDR: begin
						// refuse code 10
						// Refused code leaves every field untouched, not only the speed
						if (vspeed_wr != `MMOI_VSPEED_BAD) begin
							interpolation_mode <= pwdata[15:0] & `MMOI_INTERP_WRITABLE;
						end
					end
					`MMOI_INTERP_STEP_ADDR: begin
						cmd_step_req <= pwdata[0];
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	reg [31:0] rd_mux;
	always @* begin
		rd_mux = 32'h0000_0000;
		case (paddr)
			`MMOI_AXIS_SELECT_ADDR: rd_mux = {30'h0, axis_sel};
			`MMOI_MOTION_MODE_ADDR: rd_mux = {16'h0, axis_motion_mode[axis_sel]};
			`MMOI_OUTPUT_LEVELS_ADDR: rd_mux = {16'h0, general_output_levels};
			`MMOI_INTERP_MODE_ADDR: rd_mux = {16'h0, interpolation_mode};
			`MMOI_JOG_STATUS_ADDR: begin
				// Pins are active low; a pressed input reads as 1
				rd_mux[AXES-1:0] = ~plus_s2;
				rd_mux[2*AXES-1:AXES] = ~minus_s2;
			end
			default: rd_mux = 32'h0000_0000;
		endcase
	end
	assign prdata = (psel & ~pwrite) ? rd_mux : 32'h0000_0000;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	// Chains reset to the idle pin level so reset gives no false edge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			plus_s1 <= {AXES{1'b1}};
			plus_s2 <= {AXES{1'b1}};
			plus_s3 <= {AXES{1'b1}};
			minus_s1 <= {AXES{1'b1}};
			minus_s2 <= {AXES{1'b1}};
			ext_s1 <= 1'b1;
			ext_s2 <= 1'b1;
			ext_s3 <= 1'b1;
		end else begin
			plus_s1 <= jog_plus_in_n;
			plus_s2 <= plus_s1;
			plus_s3 <= plus_s2;
			minus_s1 <= jog_minus_in_n;
			minus_s2 <= minus_s1;
			ext_s1 <= external_step_input_n;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
		end
	end

	// Minus edge needs a third stage only for fixed mode
	reg [AXES-1:0] minus_s3;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			minus_s3 <= {AXES{1'b1}};
		end else begin
			minus_s3 <= minus_s2;
		end
	end

	// ----------------------------------------------------------------
	// Per-axis decode and outputs
	// ----------------------------------------------------------------
	reg [15:0] m;
	reg [AXES*4-1:0] next_upper;
	reg [AXES-1:0] next_pc, next_mc, next_ps, next_ms;
	reg [AXES-1:0] plus_fall, plus_rise, minus_fall;
	reg [AXES-1:0] minus_held;
	integer a;
	always @* begin
		m = 16'h0000;
		next_upper = {AXES*4{1'b0}};
		next_pc = {AXES{1'b0}};
		next_mc = {AXES{1'b0}};
		next_ps = {AXES{1'b0}};
		next_ms = {AXES{1'b0}};
		plus_fall = plus_s3 & ~plus_s2;
		plus_rise = ~plus_s3 & plus_s2;
		minus_fall = minus_s3 & ~minus_s2;
		// Pulser needs minus already low, so a fresh minus fall still starts its own drive
		minus_held = ~minus_s3 & ~minus_s2;
		for (a = 0; a < AXES; a = a + 1) begin
			m = axis_motion_mode[a];
			if (m[`MMOI_STATUS_OUT_BIT]) begin
				next_upper[a*4] = pos_at_or_above_plus[a];
				next_upper[a*4+1] = pos_below_minus[a];
				next_upper[a*4+2] = drive_accelerating[a];
				next_upper[a*4+3] = drive_decelerating[a];
			end else begin
				next_upper[a*4+3 -: 4] = m[`MMOI_UPPER_LSB+3:`MMOI_UPPER_LSB];
			end
			case (jog_code(m))
				`MMOI_JOG_CONT: begin
					next_pc[a] = ~plus_s2[a];
					next_mc[a] = ~minus_s2[a];
				end
				`MMOI_JOG_FIXED: begin
					if (minus_held[a]) begin
						next_ps[a] = plus_rise[a] | plus_fall[a];
					end else begin
						next_ps[a] = plus_fall[a];
						next_ms[a] = minus_fall[a];
					end
				end
				default: begin
				end
			endcase
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upper_axis_outputs <= {AXES*4{1'b0}};
			lower_axis_outputs <= {AXES*4{1'b0}};
			manual_decel_select <= {AXES{1'b0}};
			ramp_asymmetry_select <= {AXES{1'b0}};
			s_curve_select <= {AXES{1'b0}};
			jog_plus_continuous <= {AXES{1'b0}};
			jog_minus_continuous <= {AXES{1'b0}};
			jog_plus_start <= {AXES{1'b0}};
			jog_minus_start <= {AXES{1'b0}};
		end else begin
			upper_axis_outputs <= next_upper;
			lower_axis_outputs <= general_output_levels[AXES*4-1:0];
			for (j = 0; j < AXES; j = j + 1) begin
				manual_decel_select[j] <= axis_motion_mode[j][`MMOI_MANUAL_DECEL_BIT];
				ramp_asymmetry_select[j] <= axis_motion_mode[j][`MMOI_ASYM_BIT];
				s_curve_select[j] <= axis_motion_mode[j][`MMOI_SCURVE_BIT];
			end
			jog_plus_continuous <= next_pc;
			jog_minus_continuous <= next_mc;
			jog_plus_start <= next_ps;
			jog_minus_start <= next_ms;
		end
	end

	// ----------------------------------------------------------------
	// Interpolation decode
	// ----------------------------------------------------------------
	wire ext_fall = ext_s3 & ~ext_s2;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			master_axis_code <= 2'h0;
			second_axis_code <= 2'h0;
			third_axis_code <= 2'h0;
			vector_speed_mode <= `MMOI_VSPEED_OFF;
			interp_step <= 1'b0;
			interp_irq <= 1'b0;
		end else begin
			master_axis_code <= field2(interpolation_mode, `MMOI_MASTER_LSB);
			second_axis_code <= field2(interpolation_mode, `MMOI_SECOND_LSB);
			third_axis_code <= interp_two_axis ? 2'h0 :
				field2(interpolation_mode, `MMOI_THIRD_LSB);
			vector_speed_mode <= field2(interpolation_mode, `MMOI_VSPEED_LSB);
			interp_step <= (interpolation_mode[`MMOI_EXT_STEP_BIT] & ext_fall) |
				(interpolation_mode[`MMOI_CMD_STEP_BIT] & cmd_step_req);
			interp_irq <= (interpolation_mode[`MMOI_INTERP_IRQ_BIT] & interp_event) |
				(interpolation_mode[`MMOI_PATTERN_IRQ_BIT] & pattern_interp_event);
		end
	end

endmodule

/* File: mmoi_top_assertions.sv */
// Port checker for the motion mode register block
`timescale 1ns/10ps
`include "mmoi_regs.vh"
module mmoi_top_chk #(
	parameter AXES = 4
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [AXES-1:0] jog_plus_start,
	input wire interp_two_axis,
	input wire [AXES*4-1:0] upper_axis_outputs,
	input wire [AXES*4-1:0] lower_axis_outputs,
	input wire [AXES-1:0] manual_decel_select,
	input wire [1:0] master_axis_code,
	input wire [1:0] second_axis_code,
	input wire [1:0] third_axis_code,
	input wire [1:0] vector_speed_mode
);
	reg [15:0] d1;
	reg [15:0] d2;
	wire wr_o = psel & penable & pwrite & (paddr == `MMOI_OUTPUT_LEVELS_ADDR);
	wire wr_c = psel & penable & pwrite & (paddr == `MMOI_INTERP_MODE_ADDR);
	wire bad = pwdata[9:8] == 2'h2;
	// Write data two edges back, when a stored value reaches the ports
	always @(posedge pclk) begin
		d1 <= pwdata[15:0];
		d2 <= d1;
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_reset;
		$rose(presetn) |-> {upper_axis_outputs, lower_axis_outputs, manual_decel_select, master_axis_code} == 0;
	endproperty
	a_reset: assert property (p_reset) else $error("outputs not clear after reset");
	property p_lower;
		wr_o ##1 !wr_o |-> ##1 lower_axis_outputs == d2;
	endproperty
	a_lower: assert property (p_lower) else $error("lower outputs differ from write");
	property p_master;
		wr_c && !bad ##1 !wr_c |-> ##1 {vector_speed_mode, master_axis_code} == {d2[9:8], d2[1:0]};
	endproperty
	a_master: assert property (p_master) else $error("master code or speed mode wrong");
	property p_second;
		wr_c && !bad ##1 !wr_c |-> ##1 second_axis_code == d2[3:2];
	endproperty
	a_second: assert property (p_second) else $error("second code wrong");
	property p_third;
		wr_c && !bad ##1 !wr_c && !interp_two_axis |-> ##1 third_axis_code == d2[5:4];
	endproperty
	a_third: assert property (p_third) else $error("third code wrong");
	property p_two;
		interp_two_axis [*2] |-> third_axis_code == 2'h0;
	endproperty
	a_two: assert property (p_two) else $error("third code used in two-axis run");
	property p_legal;
		vector_speed_mode != 2'h2;
	endproperty
	a_legal: assert property (p_legal) else $error("speed mode shows code 10");
	property p_refuse;
		wr_c && bad ##1 !wr_c |-> ##1 $stable(vector_speed_mode) && $stable(master_axis_code);
	endproperty
	a_refuse: assert property (p_refuse) else $error("refused write took effect");
	property p_pulse;
		(jog_plus_start & $past(jog_plus_start)) == 0;
	endproperty
	a_pulse: assert property (p_pulse) else $error("jog start longer than one cycle");
endmodule
bind mmoi_top mmoi_top_chk #(.AXES(AXES)) chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.jog_plus_start, .interp_two_axis, .upper_axis_outputs, .lower_axis_outputs, .manual_decel_select,
	.master_axis_code, .second_axis_code, .third_axis_code, .vector_speed_mode);

/* File: tb_top.sv */
// Self-checking bench for the motion mode register block
`timescale 1ns/10ps
`include "mmoi_regs.vh"
`define CHK(g, x) begin samples_checked = samples_checked + 1; if ((g) !== (x)) begin mismatches = mismatches + 1; \
$display("mismatch at %0t: got %h want %h", $time, g, x); end end
module tb_top;
	reg pclk = 1'b0;
	reg presetn = 1'b0;
	reg [3:0] jp_n = 4'hf, jm_n = 4'hf, ph = 4'h0, pl = 4'h0, acc = 4'h0, dec = 4'h0;
	reg ext_n = 1'b1, two_ax = 1'b0, iev = 1'b0, pev = 1'b0, err;
	reg [31:0] rd;
	reg [23:0] rows [0:3];
	integer mismatches = 0, samples_checked = 0, i, n_ps = 0, n_ms = 0, n_st = 0, n_irq = 0;
	wire psel, penable, pwrite, pready, pslverr, istep, iirq;
	wire [11:0] paddr;
	wire [31:0] pwdata, prdata;
	wire [15:0] up, lo;
	wire [3:0] mds, ras, scs, jpc, jmc, jps, jms;
	wire [1:0] mac, sac, tac, vsm;
	mmoi_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	mmoi_top #(.AXES(4)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .jog_plus_in_n(jp_n),
		.jog_minus_in_n(jm_n), .external_step_input_n(ext_n), .pos_at_or_above_plus(ph), .pos_below_minus(pl),
		.drive_accelerating(acc), .drive_decelerating(dec), .interp_two_axis(two_ax), .interp_event(iev),
		.pattern_interp_event(pev), .upper_axis_outputs(up), .lower_axis_outputs(lo), .manual_decel_select(mds),
		.ramp_asymmetry_select(ras), .s_curve_select(scs), .jog_plus_continuous(jpc), .jog_minus_continuous(jmc),
		.jog_plus_start(jps), .jog_minus_start(jms), .master_axis_code(mac), .second_axis_code(sac),
		.third_axis_code(tac), .vector_speed_mode(vsm), .interp_step(istep), .interp_irq(iirq));
	initial begin
		forever #4 pclk = ~pclk;
	end
	// Pulse counters run whenever presetn is high, bus cycles included, so no pulse is lost during a bus cycle
	always @(posedge pclk) begin
		if (presetn) begin
			n_ps <= n_ps + jps[0];
			n_ms <= n_ms + jms[0];
			n_st <= n_st + istep;
			n_irq <= n_irq + iirq;
		end
	end
	task finish_test;
		begin
			$display("checks %0d mismatches %0d", samples_checked, mismatches);
			if (mismatches == 0 && samples_checked > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	task wait_cyc(input integer k);
		repeat (k) begin
			@(posedge pclk);
		end
	endtask
	task wr(input [11:0] a, input [15:0] d);
		begin
			host.xfer(a, {16'h0000, d}, 1'b1, rd, err);
			wait_cyc(1);
		end
	endtask
	initial begin
		#100000;
		mismatches = mismatches + 1;
		finish_test;
	end
	initial begin
		rows[0] = 24'h000000;
		rows[1] = 24'h00ff3f;
		rows[2] = 24'h013979;
		rows[3] = 24'h0324e4;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		wait_cyc(1);
		`CHK({up, lo, mds, ras, scs, mac, sac, tac, vsm}, 52'h0)
		for (i = 0; i < 4; i = i + 1) begin
			wr(`MMOI_INTERP_MODE_ADDR, rows[i][23:8]);
			`CHK({vsm, tac, sac, mac}, rows[i][7:0])
		end
		wr(`MMOI_INTERP_MODE_ADDR, 16'h0200);
		`CHK({vsm, mac}, 4'hc)
		two_ax <= 1'b1;
		wait_cyc(3);
		`CHK(tac, 2'h0)
		two_ax <= 1'b0;
		wr(`MMOI_AXIS_SELECT_ADDR, 16'h0002);
		wr(`MMOI_MOTION_MODE_ADDR, 16'hfa67);
		host.xfer(`MMOI_MOTION_MODE_ADDR, 32'h0, 1'b0, rd, err);
		`CHK(rd[15:0], 16'h0a07)
		`CHK({mds, ras, scs, up}, {12'h444, 16'h0a00})
		ph <= 4'h2;
		acc <= 4'h4;
		dec <= 4'h2;
		wr(`MMOI_AXIS_SELECT_ADDR, 16'h0001);
		wr(`MMOI_MOTION_MODE_ADDR, 16'h0080);
		`CHK(up, 16'h0a90)
		ph <= 4'h0;
		pl <= 4'h2;
		acc <= 4'h2;
		wait_cyc(3);
		`CHK(up, 16'h0ae0)
		wr(`MMOI_OUTPUT_LEVELS_ADDR, 16'ha5c3);
		host.xfer(12'hff0, 32'h0000ffff, 1'b1, rd, err);
		`CHK({err, lo}, 17'h1a5c3)
		wr(`MMOI_AXIS_SELECT_ADDR, 16'h0000);
		for (i = 0; i < 4; i = i + 1) begin
			wr(`MMOI_MOTION_MODE_ADDR, {11'h000, i[1:0], 3'h0});
			jp_n <= 4'he;
			wait_cyc(6);
			`CHK({jpc[0], n_ps}, {i == 1, (i >= 2) ? 1 : 0})
			jp_n <= 4'hf;
			wait_cyc(6);
		end
		wr(`MMOI_MOTION_MODE_ADDR, 16'h0010);
		jm_n <= 4'he;
		wait_cyc(6);
		jp_n <= 4'he;
		wait_cyc(6);
		jp_n <= 4'hf;
		wait_cyc(6);
		`CHK(n_ps, 3)
		`CHK(n_ms, 1)
		wr(`MMOI_MOTION_MODE_ADDR, 16'h0008);
		wait_cyc(4);
		`CHK(jmc[0], 1'b1)
		jm_n <= 4'hf;
		wr(`MMOI_INTERP_MODE_ADDR, 16'h4800);
		ext_n <= 1'b0;
		wait_cyc(6);
		`CHK(n_st, 1)
		wr(`MMOI_INTERP_STEP_ADDR, 16'h0001);
		wait_cyc(3);
		`CHK(n_st, 1)
		wr(`MMOI_INTERP_MODE_ADDR, 16'h5000);
		wr(`MMOI_INTERP_STEP_ADDR, 16'h0001);
		wait_cyc(3);
		`CHK(n_st, 2)
		pev <= 1'b1;
		wait_cyc(1);
		pev <= 1'b0;
		wait_cyc(3);
		`CHK(n_irq, 0)
		iev <= 1'b1;
		wait_cyc(1);
		iev <= 1'b0;
		wait_cyc(3);
		`CHK(n_irq, 1)
		ext_n <= 1'b1;
		wr(`MMOI_INTERP_MODE_ADDR, 16'h0000);
		wr(`MMOI_INTERP_STEP_ADDR, 16'h0001);
		wait_cyc(3);
		`CHK(n_st, 2)
		presetn <= 1'b0;
		wait_cyc(2);
		presetn <= 1'b1;
		wait_cyc(2);
		`CHK({lo, up}, 32'h0)
		finish_test;
	end
endmodule
